// ==== pkg/clcd_params.svh ====
// Constants for the character display instruction decoder.
`ifndef CLCD_PARAMS_SVH
`define CLCD_PARAMS_SVH

`define CLCD_CLK_NS 4
`define CLCD_T_INIT_NS 40000000
`define CLCD_T_CMD_NS 18500
`define CLCD_T_CLR_NS 760000
`define CLCD_INIT_CYC ((`CLCD_T_INIT_NS + `CLCD_CLK_NS - 1) / `CLCD_CLK_NS)
`define CLCD_CMD_CYC ((`CLCD_T_CMD_NS + `CLCD_CLK_NS - 1) / `CLCD_CLK_NS)
`define CLCD_CLR_CYC ((`CLCD_T_CLR_NS + `CLCD_CLK_NS - 1) / `CLCD_CLK_NS)

`define CLCD_FS_WIDTH_BIT 4
`define CLCD_FS_LINES_BIT 3
`define CLCD_FS_TALL_BIT 2
`define CLCD_FS_TABLE_BIT 0

`define CLCD_RST_OSC_TRIM 3'h4
`define CLCD_RST_CONTRAST 6'h20
`define CLCD_RST_GAIN 3'h2
`define CLCD_FILL_CHAR 8'h20

`define CLCD_ONE_LINE_LAST 7'h4F
`define CLCD_LINE1_LAST 7'h27
`define CLCD_LINE2_FIRST 7'h40
`define CLCD_LINE2_LAST 7'h67

`endif

// ==== pkg/clcd_pkg.sv ====
// Types shared by the display decoder and its host end.
`default_nettype none
package clcd_pkg;
  typedef enum logic [1:0] {
    CLCD_RAM_TEXT = 2'b00,
    CLCD_RAM_GLYPH = 2'b01,
    CLCD_RAM_SYMBOL = 2'b10
  } clcd_ram_e;
  typedef enum logic [1:0] {
    CLCD_H_IDLE = 2'b00,
    CLCD_H_GO = 2'b01,
    CLCD_H_STROBE = 2'b10,
    CLCD_H_CAPTURE = 2'b11
  } clcd_hstate_e;
endpackage
`default_nettype wire

// ==== pkg/clcd_if.sv ====
// Parallel host bus between the display decoder and the host processor.
`default_nettype none
interface clcd_if;
  logic enable_strobe;
  logic register_select;
  logic read_write;
  logic chip_select_n;
  logic external_reset_n;
  logic [7:0] host_db;
  logic host_db_oe_n;
  logic [7:0] dev_db;
  logic dev_db_oe_n;
  logic [7:0] db;

  // Undriven lines read high, as with a pull-up.
  assign db = !host_db_oe_n ? host_db : (!dev_db_oe_n ? dev_db : 8'hFF);

  modport host (
    output enable_strobe, register_select, read_write, chip_select_n,
    output external_reset_n, host_db, host_db_oe_n,
    input db
  );
  modport device (
    input enable_strobe, register_select, read_write, chip_select_n,
    input external_reset_n, db,
    output dev_db, dev_db_oe_n
  );
endinterface
`default_nettype wire

// ==== src/clcd_ram.sv ====
// Flip-flop RAM with single-cycle fill, used for text, glyph and symbol storage.
`default_nettype none
module clcd_ram #(
  parameter int AW = 7,
  parameter int DW = 8,
  parameter logic [DW-1:0] RST_VAL = '0
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic clear_i,
  input wire logic [DW-1:0] fill_i,
  input wire logic we_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem [2**AW];

  for (genvar i = 0; i < 2**AW; i++) begin : g_entry
    always_ff @(posedge mclk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        mem[i] <= RST_VAL;
      end else if (clear_i) begin
        mem[i] <= fill_i;
      end else if (we_i && addr_i == AW'(i)) begin
        mem[i] <= wdata_i;
      end
    end
  end

  assign rdata_o = mem[addr_i];
endmodule
`default_nettype wire

// ==== src/clcd_device.sv ====
// Instruction decoder and host bus end of the character display controller.
`default_nettype none
`include "clcd_params.svh"

module clcd_device
  import clcd_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = `CLCD_INIT_CYC,
  parameter int unsigned CMD_CYCLES = `CLCD_CMD_CYC,
  parameter int unsigned CLR_CYCLES = `CLCD_CLR_CYC
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  clcd_if.device bus,
  input wire logic extension_mode_pin_i,
  input wire logic supply_option_a_i,
  input wire logic supply_option_b_i,
  input wire logic clock_source_pin_i,
  output logic bus_width_select_o,
  output logic two_line_o,
  output logic tall_font_select_o,
  output logic table_select_o,
  output logic display_on_o,
  output logic cursor_on_o,
  output logic blink_on_o,
  output logic step_up_o,
  output logic display_shift_o,
  output logic bias_quarter_o,
  output logic [2:0] osc_trim_o,
  output logic icon_enable_o,
  output logic pump_enable_o,
  output logic follower_enable_o,
  output logic [5:0] contrast_level_o,
  output logic [2:0] gain_ratio_o,
  output logic busy_indicator_o,
  output logic [6:0] address_pointer_o
);
  logic bias_select_reg;
  logic nibble_phase_reg;
  logic [3:0] upper_nibble_reg;
  logic [7:0] read_hold_reg;
  logic [23:0] busy_cnt_reg;
  clcd_ram_e target_reg;
  logic [7:0] text_rd;
  logic [7:0] glyph_rd;
  logic [7:0] symbol_rd;

  wire logic init_req = !bus.external_reset_n;
  wire logic strobe = bus.enable_strobe && !bus.chip_select_n;
  wire logic four_bit = !bus_width_select_o;
  wire logic last_part = !four_bit || nibble_phase_reg;
  wire logic xfer = strobe && last_part;
  wire logic busy = busy_cnt_reg != 24'h000000;
  wire logic [7:0] wbyte = four_bit ? {upper_nibble_reg, bus.db[7:4]} : bus.db;
  wire logic cmd = xfer && !bus.register_select && !bus.read_write && !busy;
  wire logic dwr = xfer && bus.register_select && !bus.read_write && !busy;
  wire logic drd = xfer && bus.register_select && bus.read_write;
  wire logic ext_tab = table_select_o && !extension_mode_pin_i;
  wire logic follower_opt = !supply_option_a_i && !supply_option_b_i;
  wire logic is_text = wbyte[7];
  wire logic is_glyph = wbyte[7:6] == 2'b01 && !ext_tab;
  wire logic is_symbol = wbyte[7:4] == 4'h4 && ext_tab;
  wire logic is_power = wbyte[7:4] == 4'h5 && ext_tab;
  wire logic is_follow = wbyte[7:4] == 4'h6 && ext_tab;
  wire logic is_contrast = wbyte[7:4] == 4'h7 && ext_tab;
  wire logic is_func = wbyte[7:5] == 3'b001;
  wire logic is_shift = wbyte[7:4] == 4'h1;
  wire logic is_disp = wbyte[7:3] == 5'h01;
  wire logic is_entry = wbyte[7:2] == 6'h01;
  wire logic is_home = wbyte[7:1] == 7'h01;
  wire logic is_clear = wbyte == 8'h01;
  wire logic clear_text = init_req || (cmd && is_clear);

  logic [7:0] ram_rd;
  always_comb begin
    unique case (target_reg)
      CLCD_RAM_GLYPH: ram_rd = glyph_rd;
      CLCD_RAM_SYMBOL: ram_rd = symbol_rd;
      default: ram_rd = text_rd;
    endcase
  end

  wire logic [7:0] rd_val = bus.register_select ? ram_rd
                                                : {busy, address_pointer_o};

  function automatic logic [6:0] step_ap(input logic [6:0] a, input logic up);
    logic [6:0] r;
    r = a;
    unique case (target_reg)
      CLCD_RAM_GLYPH: r = {1'b0, up ? 6'(a[5:0] + 6'h01) : 6'(a[5:0] - 6'h01)};
      CLCD_RAM_SYMBOL: r = {3'b000, up ? 4'(a[3:0] + 4'h1) : 4'(a[3:0] - 4'h1)};
      default: begin
        if (!two_line_o) begin
          if (up) begin
            r = (a >= `CLCD_ONE_LINE_LAST) ? 7'h00 : 7'(a + 7'h01);
          end else begin
            r = (a == 7'h00) ? `CLCD_ONE_LINE_LAST : 7'(a - 7'h01);
          end
        end else if (up) begin
          if (a == `CLCD_LINE1_LAST) begin
            r = `CLCD_LINE2_FIRST;
          end else begin
            r = (a >= `CLCD_LINE2_LAST) ? 7'h00 : 7'(a + 7'h01);
          end
        end else begin
          if (a == 7'h00) begin
            r = `CLCD_LINE2_LAST;
          end else begin
            r = (a == `CLCD_LINE2_FIRST) ? `CLCD_LINE1_LAST : 7'(a - 7'h01);
          end
        end
      end
    endcase
    return r;
  endfunction

  // Mode and analog control settings.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i || init_req) begin
      bus_width_select_o <= 1'b1;
      two_line_o <= 1'b0;
      tall_font_select_o <= 1'b0;
      table_select_o <= 1'b0;
      display_on_o <= 1'b0;
      cursor_on_o <= 1'b0;
      blink_on_o <= 1'b0;
      step_up_o <= 1'b1;
      display_shift_o <= 1'b0;
      bias_select_reg <= 1'b0;
      osc_trim_o <= `CLCD_RST_OSC_TRIM;
      icon_enable_o <= 1'b0;
      pump_enable_o <= 1'b0;
      follower_enable_o <= 1'b0;
      contrast_level_o <= `CLCD_RST_CONTRAST;
      gain_ratio_o <= `CLCD_RST_GAIN;
    end else if (cmd) begin
      if (is_func) begin
        bus_width_select_o <= wbyte[`CLCD_FS_WIDTH_BIT];
        two_line_o <= wbyte[`CLCD_FS_LINES_BIT];
        tall_font_select_o <= wbyte[`CLCD_FS_TALL_BIT];
        table_select_o <= wbyte[`CLCD_FS_TABLE_BIT];
      end
      if (is_disp) begin
        display_on_o <= wbyte[2];
        cursor_on_o <= wbyte[1];
        blink_on_o <= wbyte[0];
      end
      if (is_entry) begin
        step_up_o <= wbyte[1];
        display_shift_o <= wbyte[0];
      end
      if (is_clear) begin
        step_up_o <= 1'b1;
      end
      if (is_shift && ext_tab) begin
        bias_select_reg <= wbyte[3];
        if (clock_source_pin_i) begin
          osc_trim_o <= wbyte[2:0];
        end
      end
      if (is_power) begin
        icon_enable_o <= wbyte[3];
        if (follower_opt) begin
          pump_enable_o <= wbyte[2];
          contrast_level_o[5:4] <= wbyte[1:0];
        end
      end
      if (is_follow && follower_opt) begin
        follower_enable_o <= wbyte[3];
        gain_ratio_o <= wbyte[2:0];
      end
      if (is_contrast && follower_opt) begin
        contrast_level_o[3:0] <= wbyte[3:0];
      end
    end
  end

  // The bias bit has no effect when both supply options pick external resistors.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bias_quarter_o <= 1'b0;
    end else begin
      bias_quarter_o <= bias_select_reg && !(supply_option_a_i && supply_option_b_i);
    end
  end

  // Address pointer and RAM target.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i || init_req) begin
      address_pointer_o <= 7'h00;
      target_reg <= CLCD_RAM_TEXT;
    end else if (cmd) begin
      if (is_text) begin
        address_pointer_o <= wbyte[6:0];
        target_reg <= CLCD_RAM_TEXT;
      end else if (is_glyph) begin
        address_pointer_o <= {1'b0, wbyte[5:0]};
        target_reg <= CLCD_RAM_GLYPH;
      end else if (is_symbol) begin
        address_pointer_o <= {3'b000, wbyte[3:0]};
        target_reg <= CLCD_RAM_SYMBOL;
      end else if (is_clear || is_home) begin
        address_pointer_o <= 7'h00;
        target_reg <= CLCD_RAM_TEXT;
      end else if (is_shift && !ext_tab && !wbyte[3]) begin
        address_pointer_o <= step_ap(address_pointer_o, wbyte[2]);
      end
    end else if (dwr || drd) begin
      address_pointer_o <= step_ap(address_pointer_o, step_up_o);
    end
  end

  // Busy timer; power-up and external reset both start the long initialisation.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_cnt_reg <= 24'(INIT_CYCLES);
    end else if (init_req) begin
      busy_cnt_reg <= 24'(INIT_CYCLES);
    end else if (cmd) begin
      busy_cnt_reg <= (is_clear || is_home) ? 24'(CLR_CYCLES) : 24'(CMD_CYCLES);
    end else if (dwr || drd) begin
      busy_cnt_reg <= 24'(CMD_CYCLES);
    end else if (busy) begin
      busy_cnt_reg <= 24'(busy_cnt_reg - 24'h000001);
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      busy_indicator_o <= 1'b1;
    end else begin
      busy_indicator_o <= busy;
    end
  end

  // Nibble pairing for the 4-bit bus.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i || init_req) begin
      nibble_phase_reg <= 1'b0;
      upper_nibble_reg <= 4'h0;
      read_hold_reg <= 8'h00;
    end else if (strobe) begin
      nibble_phase_reg <= four_bit && !nibble_phase_reg;
      if (!nibble_phase_reg) begin
        upper_nibble_reg <= bus.db[7:4];
        read_hold_reg <= rd_val;
      end
    end
  end

  // Read data is driven for one cycle after the strobe.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus.dev_db <= 8'h00;
      bus.dev_db_oe_n <= 1'b1;
    end else if (strobe && bus.read_write) begin
      bus.dev_db_oe_n <= 1'b0;
      if (!four_bit) begin
        bus.dev_db <= rd_val;
      end else if (!nibble_phase_reg) begin
        bus.dev_db <= {rd_val[7:4], 4'h0};
      end else begin
        bus.dev_db <= {read_hold_reg[3:0], 4'h0};
      end
    end else begin
      bus.dev_db_oe_n <= 1'b1;
    end
  end

  clcd_ram #(.AW(7), .DW(8), .RST_VAL(`CLCD_FILL_CHAR)) u_text (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clear_i(clear_text),
    .fill_i(`CLCD_FILL_CHAR),
    .we_i(dwr && target_reg == CLCD_RAM_TEXT),
    .addr_i(address_pointer_o),
    .wdata_i(wbyte),
    .rdata_o(text_rd)
  );

  clcd_ram #(.AW(6), .DW(8), .RST_VAL(8'h00)) u_glyph (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clear_i(1'b0),
    .fill_i(8'h00),
    .we_i(dwr && target_reg == CLCD_RAM_GLYPH),
    .addr_i(address_pointer_o[5:0]),
    .wdata_i(wbyte),
    .rdata_o(glyph_rd)
  );

  clcd_ram #(.AW(4), .DW(8), .RST_VAL(8'h00)) u_symbol (
    .mclk_i(mclk_i),
    .rstn_i(rstn_i),
    .clear_i(1'b0),
    .fill_i(8'h00),
    .we_i(dwr && target_reg == CLCD_RAM_SYMBOL),
    .addr_i(address_pointer_o[3:0]),
    .wdata_i(wbyte),
    .rdata_o(symbol_rd)
  );
endmodule
`default_nettype wire

// ==== src/clcd_host.sv ====
// Host end: runs one bus transfer per request, polling busy first except for status reads.
`default_nettype none
module clcd_host
  import clcd_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  clcd_if.host bus,
  input wire logic four_bit_i,
  input wire logic reset_req_i,
  input wire logic req_valid_i,
  input wire logic req_rs_i,
  input wire logic req_rw_i,
  input wire logic [7:0] req_data_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [7:0] rsp_data_o
);
  clcd_hstate_e state_reg;
  logic polling_reg;
  logic nibble_reg;
  logic rs_reg;
  logic rw_reg;
  logic [7:0] data_reg;
  logic [7:0] cap_reg;

  wire logic [7:0] cap_next = !four_bit_i ? bus.db
                            : (nibble_reg ? {cap_reg[7:4], bus.db[7:4]}
                                          : {bus.db[7:4], 4'h0});

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bus.external_reset_n <= 1'b1;
    end else begin
      bus.external_reset_n <= !reset_req_i;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= CLCD_H_IDLE;
      polling_reg <= 1'b0;
      nibble_reg <= 1'b0;
      rs_reg <= 1'b0;
      rw_reg <= 1'b0;
      data_reg <= 8'h00;
      cap_reg <= 8'h00;
      req_ready_o <= 1'b1;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= 8'h00;
      bus.enable_strobe <= 1'b0;
      bus.register_select <= 1'b0;
      bus.read_write <= 1'b1;
      bus.chip_select_n <= 1'b1;
      bus.host_db <= 8'h00;
      bus.host_db_oe_n <= 1'b1;
    end else begin
      rsp_valid_o <= 1'b0;
      unique case (state_reg)
        CLCD_H_IDLE: begin
          if (req_valid_i) begin
            req_ready_o <= 1'b0;
            rs_reg <= req_rs_i;
            rw_reg <= req_rw_i;
            data_reg <= req_data_i;
            polling_reg <= req_rs_i || !req_rw_i;
            nibble_reg <= 1'b0;
            bus.chip_select_n <= 1'b0;
            state_reg <= CLCD_H_GO;
          end
        end
        CLCD_H_GO, CLCD_H_CAPTURE: begin
          if (state_reg == CLCD_H_CAPTURE) begin
            cap_reg <= cap_next;
          end
          if (state_reg == CLCD_H_CAPTURE && !(four_bit_i && !nibble_reg) && polling_reg
              && !cap_next[7]) begin
            polling_reg <= 1'b0;
            nibble_reg <= 1'b0;
            bus.enable_strobe <= 1'b1;
            bus.register_select <= rs_reg;
            bus.read_write <= rw_reg;
            bus.host_db <= four_bit_i ? {data_reg[7:4], 4'h0} : data_reg;
            bus.host_db_oe_n <= rw_reg;
            state_reg <= CLCD_H_STROBE;
          end else if (state_reg == CLCD_H_CAPTURE && !(four_bit_i && !nibble_reg)
                       && !polling_reg) begin
            rsp_valid_o <= 1'b1;
            rsp_data_o <= cap_next;
            req_ready_o <= 1'b1;
            bus.chip_select_n <= 1'b1;
            state_reg <= CLCD_H_IDLE;
          end else begin
            if (state_reg == CLCD_H_CAPTURE) begin
              nibble_reg <= four_bit_i && !nibble_reg;
            end
            bus.enable_strobe <= 1'b1;
            bus.register_select <= polling_reg ? 1'b0 : rs_reg;
            bus.read_write <= polling_reg ? 1'b1 : rw_reg;
            bus.host_db <= (four_bit_i && state_reg == CLCD_H_CAPTURE && !nibble_reg)
                           ? {data_reg[3:0], 4'h0}
                           : (four_bit_i ? {data_reg[7:4], 4'h0} : data_reg);
            bus.host_db_oe_n <= polling_reg || rw_reg;
            state_reg <= CLCD_H_STROBE;
          end
        end
        CLCD_H_STROBE: begin
          bus.enable_strobe <= 1'b0;
          bus.host_db_oe_n <= 1'b1;
          state_reg <= CLCD_H_CAPTURE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/clcd_bus_asserts.sv ====
// Protocol checker for the parallel host bus between both display ends.
`default_nettype none
module clcd_bus_asserts (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic enable_strobe,
  input wire logic read_write,
  input wire logic chip_select_n,
  input wire logic external_reset_n,
  input wire logic host_db_oe_n,
  input wire logic dev_db_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rstn_i);

  sequence s_read_req;
    enable_strobe && !chip_select_n && read_write;
  endsequence
  sequence s_dev_answer;
    !dev_db_oe_n ##1 dev_db_oe_n;
  endsequence

  a_read_answer_once: assert property (s_read_req |=> s_dev_answer)
    else $error("device read answer missing or too long");
  a_answer_has_cause: assert property (!dev_db_oe_n |->
    $past(enable_strobe) && !$past(chip_select_n) && $past(read_write))
    else $error("device drove the bus without a read strobe");
  a_write_no_drive: assert property (enable_strobe && !chip_select_n && !read_write |=>
    dev_db_oe_n)
    else $error("device drove the bus after a write strobe");
  a_no_contention: assert property (host_db_oe_n || dev_db_oe_n)
    else $error("both ends drive the data bus");
  a_cs_lead_strobe: assert property (enable_strobe |-> !chip_select_n && !$past(chip_select_n))
    else $error("strobe without chip select held low beforehand");
  a_write_host_drives: assert property (enable_strobe && !read_write |-> !host_db_oe_n)
    else $error("host not driving data on a write strobe");
  a_read_host_off: assert property (enable_strobe && read_write |=> host_db_oe_n)
    else $error("host still drives the bus during read answer");
  a_reinit_quiet: assert property (!external_reset_n |=> dev_db_oe_n [*2])
    else $error("device drives the bus while reinitialising");
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// Self-checking bench joining the display decoder to its host end.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i, rstn_i, four_bit, reset_req, req_valid, req_rs, req_rw, req_ready, rsp_valid;
  logic [7:0] req_data, rsp_data;
  logic ext_pin, opt_a, opt_b, clk_src, mon_on;
  logic bw, two_line, tall, tsel, disp, cur, blink, step_up, bias_q, icon, pump, foll, busy;
  logic dshift;
  logic [2:0] trim, gain;
  logic [5:0] contr;
  logic [6:0] ptr;
  logic [7:0] wq[$];
  int err_total, n_tests;

  always #2 mclk_i = ~mclk_i;

  clcd_if bus ();
  clcd_device #(.INIT_CYCLES(50), .CMD_CYCLES(3), .CLR_CYCLES(5)) clcd_device_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus), .extension_mode_pin_i(ext_pin),
    .supply_option_a_i(opt_a), .supply_option_b_i(opt_b), .clock_source_pin_i(clk_src),
    .bus_width_select_o(bw), .two_line_o(two_line), .tall_font_select_o(tall),
    .table_select_o(tsel), .display_on_o(disp), .cursor_on_o(cur), .blink_on_o(blink),
    .step_up_o(step_up), .display_shift_o(dshift), .bias_quarter_o(bias_q), .osc_trim_o(trim),
    .icon_enable_o(icon), .pump_enable_o(pump), .follower_enable_o(foll),
    .contrast_level_o(contr), .gain_ratio_o(gain), .busy_indicator_o(busy),
    .address_pointer_o(ptr));
  clcd_host clcd_host_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .bus(bus), .four_bit_i(four_bit),
    .reset_req_i(reset_req), .req_valid_i(req_valid), .req_rs_i(req_rs), .req_rw_i(req_rw),
    .req_data_i(req_data), .req_ready_o(req_ready), .rsp_valid_o(rsp_valid),
    .rsp_data_o(rsp_data));
  clcd_bus_asserts clcd_bus_asserts_inst (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .enable_strobe(bus.enable_strobe),
    .read_write(bus.read_write), .chip_select_n(bus.chip_select_n),
    .external_reset_n(bus.external_reset_n), .host_db_oe_n(bus.host_db_oe_n),
    .dev_db_oe_n(bus.dev_db_oe_n));

  // Records the bus byte of every write strobe while enabled.
  always @(posedge mclk_i) begin
    if (mon_on && bus.enable_strobe && !bus.chip_select_n && !bus.read_write) begin
      wq.push_back(bus.db);
    end
  end

  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d);
    int k;
    @(negedge mclk_i);
    req_valid = 1'b1;
    req_rs = rs;
    req_rw = rw;
    req_data = d;
    @(negedge mclk_i);
    req_valid = 1'b0;
    k = 0;
    while (rsp_valid !== 1'b1 && k < 300) begin
      @(negedge mclk_i);
      k++;
    end
    chk("response", 8'h03, {6'h00, req_ready, rsp_valid});
  endtask

  task automatic idle_wait();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 100) begin
      @(negedge mclk_i);
      k++;
    end
  endtask

  task automatic chk_defaults();
    chk("modes", 8'h81, {bw, two_line, tall, tsel, disp, cur, blink, step_up});
    chk("power", 8'h04, {bias_q, icon, pump, foll, 1'b0, trim});
    chk("contrast", 8'h20, {2'h0, contr});
    chk("gain", 8'h02, {5'h00, gain});
    chk("busy", 8'h01, {7'h00, busy});
    chk("shift", 8'h00, {7'h00, dshift});
  endtask

  task automatic print_verdict();
    $display("Checks made %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_total++;
    $display("BAD watchdog expected finish seen hang");
    print_verdict();
  end

  initial begin
    {mclk_i, rstn_i, four_bit, reset_req, req_valid, req_rs, req_rw, mon_on} = 8'h00;
    {ext_pin, opt_a, opt_b, clk_src} = 4'h1;
    req_data = 8'h00;
    err_total = 0;
    n_tests = 0;
    repeat (3) @(negedge mclk_i);
    rstn_i = 1'b1;
    chk_defaults();
    xfer(0, 0, 8'h80);
    xfer(1, 1, 8'h00);
    chk("cleared text", 8'h20, rsp_data);
    mon_on = 1'b1;
    xfer(0, 0, 8'h85);
    mon_on = 1'b0;
    chk("pointer", 8'h05, {1'b0, ptr});
    chk("strobes", 8'h01, 8'(wq.size()));
    chk("wire byte", 8'h85, wq[0]);
    xfer(1, 0, 8'h41);
    chk("pointer", 8'h06, {1'b0, ptr});
    xfer(0, 0, 8'h85);
    xfer(1, 1, 8'h00);
    chk("text data", 8'h41, rsp_data);
    chk("pointer", 8'h06, {1'b0, ptr});
    idle_wait();
    xfer(0, 1, 8'h00);
    chk("status", 8'h06, rsp_data);
    xfer(0, 0, 8'h05);
    xfer(1, 0, 8'h42);
    chk("step down", 8'h05, {1'b0, ptr});
    xfer(0, 0, 8'h01);
    chk("clear ptr", 8'h00, {1'b0, ptr});
    chk("clear step", 8'h01, {7'h00, step_up});
    xfer(0, 0, 8'h14);
    chk("cursor shift", 8'h01, {1'b0, ptr});
    xfer(0, 0, 8'h0F);
    $display("test text ram done");
    xfer(0, 0, 8'h39);
    chk("modes", 8'hDF, {bw, two_line, tall, tsel, disp, cur, blink, step_up});
    xfer(0, 0, 8'hC0);
    chk("line two", 8'h40, {1'b0, ptr});
    xfer(0, 0, 8'h1B);
    chk("bias trim", 8'h83, {bias_q, 4'h0, trim});
    xfer(0, 0, 8'h5E);
    xfer(0, 0, 8'h7A);
    chk("icon pump", 8'h03, {6'h00, icon, pump});
    chk("contrast", 8'h2A, {2'h0, contr});
    xfer(0, 0, 8'h6D);
    chk("follower", 8'h0D, {4'h0, foll, gain});
    xfer(0, 0, 8'h43);
    chk("symbol ptr", 8'h03, {1'b0, ptr});
    xfer(1, 0, 8'h99);
    xfer(0, 0, 8'h43);
    xfer(1, 1, 8'h00);
    chk("symbol data", 8'h99, rsp_data);
    {opt_a, opt_b, clk_src} = 3'b110;
    xfer(0, 0, 8'h68);
    xfer(0, 0, 8'h71);
    xfer(0, 0, 8'h1F);
    xfer(0, 0, 8'h50);
    chk("bias off", 8'h00, {7'h00, bias_q});
    chk("gain kept", 8'h05, {5'h00, gain});
    chk("contr kept", 8'h2A, {2'h0, contr});
    chk("trim kept", 8'h03, {5'h00, trim});
    chk("icon pump", 8'h01, {6'h00, icon, pump});
    {opt_a, opt_b, clk_src, ext_pin} = 4'b0011;
    xfer(0, 0, 8'h55);
    chk("glyph ptr", 8'h15, {1'b0, ptr});
    chk("icon kept", 8'h00, {7'h00, icon});
    ext_pin = 1'b0;
    $display("test extension done");
    reset_req = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk_defaults();
    reset_req = 1'b0;
    xfer(0, 0, 8'h28);
    chk("width", 8'h00, {7'h00, bw});
    four_bit = 1'b1;
    wq.delete();
    mon_on = 1'b1;
    xfer(0, 0, 8'h45);
    mon_on = 1'b0;
    chk("glyph ptr", 8'h05, {1'b0, ptr});
    chk("nibble hi", 8'h04, {4'h0, wq[0][7:4]});
    chk("nibble lo", 8'h05, {4'h0, wq[1][7:4]});
    xfer(1, 0, 8'hA5);
    xfer(0, 0, 8'h45);
    xfer(1, 1, 8'h00);
    chk("glyph data", 8'hA5, rsp_data);
    idle_wait();
    xfer(0, 1, 8'h00);
    chk("status", 8'h06, rsp_data);
    $display("test four bit done");
    print_verdict();
  end
endmodule
`default_nettype wire
